// [verilog/acl_cal_open_loop.v]
// Calibration length, automatic open-loop fallback and open-loop drive configuration.
`timescale 1ns/100ps
`default_nettype none
`include "acl_defines.vh"
module acl_cal_open_loop #(
    parameter [27:0] CAL0_CYCLES = `ACL_CAL0_CYCLES,
    parameter [27:0] CAL1_CYCLES = `ACL_CAL1_CYCLES,
    parameter [27:0] CAL2_CYCLES = `ACL_CAL2_CYCLES,
    parameter [27:0] MEAS_CYCLES = `ACL_MEAS_CYCLES,
    parameter [12:0] OL_UNIT_CYCLES = `ACL_OL_UNIT_CYCLES
) (
    input wire clk_i,
    input wire rst_i,
    input wire [7:0] reg_addr_i,
    input wire reg_wr_i,
    input wire [7:0] reg_wdata_i,
    input wire reg_rd_i,
    output reg [7:0] reg_rdata_o,
    input wire cal_start_i,
    input wire ext_trig_i,
    input wire enable_trig_i,
    input wire sw_trig_i,
    output wire cal_busy_o,
    output wire cal_measure_o,
    output reg cal_done_o,
    input wire closed_loop_active_i,
    input wire open_loop_req_i,
    input wire zero_crossing_window_i,
    input wire zero_crossing_seen_i,
    output wire open_loop_o,
    output wire fallback_active_o,
    output wire drive_sine_o,
    output wire drive_polarity_o,
    output wire drive_cycle_o
);

// ----------------------------------------------------------------------------
// Register bank
// ----------------------------------------------------------------------------
reg [7:0] calibration_time_cfg_reg;
reg [7:0] open_loop_control_reg;
reg [7:0] open_loop_period_upper_reg;
reg [7:0] open_loop_period_lower_reg;

// Reserved bits are stored whole so reads return what was written.
always @(posedge clk_i) begin
    if (rst_i) begin
        calibration_time_cfg_reg <= `ACL_CAL_TIME_CFG_RST;
        open_loop_control_reg <= `ACL_OPEN_LOOP_CTRL_RST;
        open_loop_period_upper_reg <= `ACL_OL_PERIOD_UPPER_RST;
        open_loop_period_lower_reg <= `ACL_OL_PERIOD_LOWER_RST;
    end else if (reg_wr_i) begin
        case (reg_addr_i)
            `ACL_CAL_TIME_CFG_ADDR: calibration_time_cfg_reg <= reg_wdata_i;
            `ACL_OPEN_LOOP_CTRL_ADDR: open_loop_control_reg <= reg_wdata_i;
            `ACL_OL_PERIOD_UPPER_ADDR: open_loop_period_upper_reg <= reg_wdata_i;
            `ACL_OL_PERIOD_LOWER_ADDR: open_loop_period_lower_reg <= reg_wdata_i;
            default: ;
        endcase
    end
end

always @(posedge clk_i) begin
    if (rst_i) begin
        reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
        case (reg_addr_i)
            `ACL_CAL_TIME_CFG_ADDR: reg_rdata_o <= calibration_time_cfg_reg;
            `ACL_OPEN_LOOP_CTRL_ADDR: reg_rdata_o <= open_loop_control_reg;
            `ACL_OL_PERIOD_UPPER_ADDR: reg_rdata_o <= open_loop_period_upper_reg;
            `ACL_OL_PERIOD_LOWER_ADDR: reg_rdata_o <= open_loop_period_lower_reg;
            default: reg_rdata_o <= 8'h00;
        endcase
    end
end

wire [1:0] cal_time_code;
wire fallback_enable_flag;
wire [1:0] fallback_attempt_setting;
wire open_drive_waveform_sel;
wire [9:0] open_drive_period;

assign cal_time_code = calibration_time_cfg_reg[`ACL_CAL_TIME_MSB:`ACL_CAL_TIME_LSB];
assign fallback_enable_flag = open_loop_control_reg[`ACL_FALLBACK_EN_BIT];
assign fallback_attempt_setting =
    open_loop_control_reg[`ACL_FALLBACK_CNT_MSB:`ACL_FALLBACK_CNT_LSB];
assign open_drive_waveform_sel = open_loop_control_reg[`ACL_WAVE_SEL_BIT];
assign open_drive_period = {open_loop_period_upper_reg[`ACL_PERIOD_HI_MSB:`ACL_PERIOD_HI_LSB],
                            open_loop_period_lower_reg};

// ----------------------------------------------------------------------------
// Calibration sequencer
// ----------------------------------------------------------------------------
localparam [1:0] CAL_IDLE = 2'b00;
localparam [1:0] CAL_RUN = 2'b01;
localparam [1:0] CAL_WAIT_TRIG = 2'b10;
localparam [1:0] CAL_MEASURE = 2'b11;

function [27:0] cal_length;
    input [1:0] code;
    begin
        case (code)
            2'h0: cal_length = CAL0_CYCLES;
            2'h1: cal_length = CAL1_CYCLES;
            default: cal_length = CAL2_CYCLES;
        endcase
    end
endfunction

reg [1:0] cal_state_reg;
reg [1:0] cal_state_next;
reg [27:0] cal_cnt_reg;
reg [27:0] cal_cnt_next;
reg cal_done_next;
wire cancel_trig;

assign cancel_trig = ext_trig_i | enable_trig_i | sw_trig_i;

// The trigger-ended run trusts the host to hold it for at least one second;
// a shorter run is not blocked here, it only gives a poor result.
always @* begin
    cal_state_next = cal_state_reg;
    cal_cnt_next = cal_cnt_reg;
    cal_done_next = 1'b0;
    case (cal_state_reg)
        CAL_IDLE: begin
            if (cal_start_i) begin
                if (cal_time_code == `ACL_CAL_CODE_TRIGGER) begin
                    cal_state_next = CAL_WAIT_TRIG;
                end else begin
                    cal_state_next = CAL_RUN;
                    cal_cnt_next = cal_length(cal_time_code) - 28'h0000001;
                end
            end
        end
        CAL_RUN: begin
            if (cal_cnt_reg == 28'h0000000) begin
                cal_state_next = CAL_MEASURE;
                cal_cnt_next = MEAS_CYCLES - 28'h0000001;
            end else begin
                cal_cnt_next = cal_cnt_reg - 28'h0000001;
            end
        end
        CAL_WAIT_TRIG: begin
            if (cancel_trig) begin
                cal_state_next = CAL_MEASURE;
                cal_cnt_next = MEAS_CYCLES - 28'h0000001;
            end
        end
        CAL_MEASURE: begin
            if (cal_cnt_reg == 28'h0000000) begin
                cal_state_next = CAL_IDLE;
                cal_done_next = 1'b1;
            end else begin
                cal_cnt_next = cal_cnt_reg - 28'h0000001;
            end
        end
        default: begin
            cal_state_next = CAL_IDLE;
            cal_cnt_next = 28'h0000000;
        end
    endcase
end

always @(posedge clk_i) begin
    if (rst_i) begin
        cal_state_reg <= CAL_IDLE;
        cal_cnt_reg <= 28'h0000000;
        cal_done_o <= 1'b0;
    end else begin
        cal_state_reg <= cal_state_next;
        cal_cnt_reg <= cal_cnt_next;
        cal_done_o <= cal_done_next;
    end
end

assign cal_busy_o = (cal_state_reg != CAL_IDLE);
assign cal_measure_o = (cal_state_reg == CAL_MEASURE);

// ----------------------------------------------------------------------------
// Automatic open-loop fallback
// ----------------------------------------------------------------------------
// Misses must be consecutive; a detected crossing starts the count again.
// Fallback holds until the closed-loop drive ends or the fallback enable bit is cleared, so the effect
// never flips back and forth between modes mid-play.
reg [2:0] miss_cnt_reg;
reg fallback_reg;
wire [2:0] miss_limit;

assign miss_limit = `ACL_FALLBACK_MIN_ATTEMPTS + {1'b0, fallback_attempt_setting};

always @(posedge clk_i) begin
    if (rst_i || !closed_loop_active_i || !fallback_enable_flag) begin
        miss_cnt_reg <= 3'h0;
        fallback_reg <= 1'b0;
    end else if (zero_crossing_window_i && !fallback_reg) begin
        if (zero_crossing_seen_i) begin
            miss_cnt_reg <= 3'h0;
        end else if (miss_cnt_reg + 3'h1 >= miss_limit) begin
            fallback_reg <= 1'b1;
        end else begin
            miss_cnt_reg <= miss_cnt_reg + 3'h1;
        end
    end
end

assign fallback_active_o = fallback_reg;
assign open_loop_o = open_loop_req_i | fallback_reg;
assign drive_sine_o = open_loop_req_i & open_drive_waveform_sel & ~fallback_reg;

// ----------------------------------------------------------------------------
// Open-loop period generator
// ----------------------------------------------------------------------------
acl_period_gen #(
    .UNIT_CYCLES(OL_UNIT_CYCLES)
) u_period_gen (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(open_loop_o),
    .period_i(open_drive_period),
    .polarity_o(drive_polarity_o),
    .cycle_o(drive_cycle_o)
);

endmodule // acl_cal_open_loop
`default_nettype wire

// [shared/acl_defines.vh]
// Offsets, field positions, reset values and timing figures of the calibration and open-loop registers.
`ifndef ACL_DEFINES_VH
`define ACL_DEFINES_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define ACL_CAL_TIME_CFG_ADDR 8'h2A
`define ACL_OPEN_LOOP_CTRL_ADDR 8'h2C
`define ACL_OL_PERIOD_UPPER_ADDR 8'h2E
`define ACL_OL_PERIOD_LOWER_ADDR 8'h2F

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define ACL_CAL_TIME_CFG_RST 8'h02
`define ACL_OPEN_LOOP_CTRL_RST 8'h00
`define ACL_OL_PERIOD_UPPER_RST 8'h00
`define ACL_OL_PERIOD_LOWER_RST 8'hC6

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define ACL_CAL_TIME_MSB 1
`define ACL_CAL_TIME_LSB 0
`define ACL_FALLBACK_EN_BIT 7
`define ACL_FALLBACK_CNT_MSB 6
`define ACL_FALLBACK_CNT_LSB 5
`define ACL_WAVE_SEL_BIT 0
`define ACL_PERIOD_HI_MSB 1
`define ACL_PERIOD_HI_LSB 0

// ----------------------------------------------------------------------------
// Codes and counts
// ----------------------------------------------------------------------------
`define ACL_CAL_CODE_TRIGGER 2'h3
`define ACL_FALLBACK_MIN_ATTEMPTS 3'h3

// ----------------------------------------------------------------------------
// Timing figures
// ----------------------------------------------------------------------------
`define ACL_CLK_PERIOD_NS 5
`define ACL_CAL_TIME_0_MS 250
`define ACL_CAL_TIME_1_MS 500
`define ACL_CAL_TIME_2_MS 1000
`define ACL_CAL_MEASURE_MS 5
// Open-loop period unit of 24.615 us, held in nanoseconds.
`define ACL_OL_UNIT_NS 24615
`define ACL_NS_PER_MS 1000000
// The same figures as clock counts at the 5 ns clock, sized to the counters that hold them.
`define ACL_CAL0_CYCLES 28'h2FAF080
`define ACL_CAL1_CYCLES 28'h5F5E100
`define ACL_CAL2_CYCLES 28'hBEBC200
`define ACL_MEAS_CYCLES 28'h00F4240
`define ACL_OL_UNIT_CYCLES 13'h133B

`endif

// [verilog/acl_period_gen.v]
// Open-loop drive period generator: square polarity and one pulse per drive period.
`timescale 1ns/100ps
`default_nettype none
module acl_period_gen #(
    parameter [12:0] UNIT_CYCLES = 13'h133B
) (
    input wire clk_i,
    input wire rst_i,
    input wire run_i,
    input wire [9:0] period_i,
    output reg polarity_o,
    output reg cycle_o
);

// ----------------------------------------------------------------------------
// Unit tick and unit counter
// ----------------------------------------------------------------------------
reg [12:0] tick_cnt_reg;
reg [9:0] unit_cnt_reg;
wire unit_tick;
wire period_end;

assign unit_tick = (tick_cnt_reg == UNIT_CYCLES - 13'h0001);
assign period_end = (unit_cnt_reg >= period_i - 10'h001);

// A period of zero would give no drive at all, so the generator stays idle there.
always @(posedge clk_i) begin
    if (rst_i || !run_i || period_i == 10'h000) begin
        tick_cnt_reg <= 13'h0000;
        unit_cnt_reg <= 10'h000;
        polarity_o <= 1'b0;
        cycle_o <= 1'b0;
    end else begin
        cycle_o <= 1'b0;
        if (unit_tick) begin
            tick_cnt_reg <= 13'h0000;
            if (period_end) begin
                unit_cnt_reg <= 10'h000;
                cycle_o <= 1'b1;
            end else begin
                unit_cnt_reg <= unit_cnt_reg + 10'h001;
            end
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 13'h0001;
        end
        polarity_o <= (unit_cnt_reg >= {1'b0, period_i[9:1]});
    end
end

endmodule // acl_period_gen
`default_nettype wire

// [bench/acl_cal_open_loop_sva.sv]
// Concurrent checks on the calibration and open-loop configuration ports.
`timescale 1ns/100ps
`default_nettype none
module acl_cal_open_loop_sva #(
    parameter [27:0] CAL0_CYCLES = 20,
    parameter [27:0] CAL1_CYCLES = 40,
    parameter [27:0] CAL2_CYCLES = 80,
    parameter [12:0] OL_UNIT_CYCLES = 4
) (
    input wire logic clk_i, rst_i, reg_wr_i, cal_start_i, ext_trig_i, enable_trig_i, sw_trig_i,
    input wire logic cal_busy_o, cal_measure_o, cal_done_o, closed_loop_active_i,
    input wire logic open_loop_req_i, zero_crossing_window_i, zero_crossing_seen_i, open_loop_o,
    input wire logic fallback_active_o, drive_sine_o, drive_cycle_o,
    input wire logic [7:0] reg_addr_i, reg_wdata_i
);
    logic [1:0] cfg_reg, code_reg;
    logic [7:0] ctl_reg;
    logic [9:0] per_reg;
    logic [2:0] miss_reg;
    logic [27:0] run_reg;
    logic [23:0] gap_reg;
    logic prev_reg;
    wire logic trig = ext_trig_i | enable_trig_i | sw_trig_i;
    wire logic win = zero_crossing_window_i;
    wire logic [27:0] cal_len = code_reg == 2'h0 ? CAL0_CYCLES :
        (code_reg == 2'h1 ? CAL1_CYCLES : CAL2_CYCLES);
    wire logic [23:0] per_len = 24'(per_reg) * 24'(OL_UNIT_CYCLES);
    always_ff @(posedge clk_i) begin
        if (reg_wr_i && reg_addr_i == 8'h2A) cfg_reg <= reg_wdata_i[1:0];
        if (reg_wr_i && reg_addr_i == 8'h2C) ctl_reg <= reg_wdata_i;
        if (reg_wr_i && reg_addr_i == 8'h2E) per_reg[9:8] <= reg_wdata_i[1:0];
        if (reg_wr_i && reg_addr_i == 8'h2F) per_reg[7:0] <= reg_wdata_i;
        if (cal_start_i && !cal_busy_o) code_reg <= cfg_reg;
        run_reg <= !cal_busy_o ? 28'h0 : run_reg + 28'(!cal_measure_o);
        if (!closed_loop_active_i || !ctl_reg[7] || (win && zero_crossing_seen_i)) miss_reg <= 3'h0;
        else if (win && miss_reg != 3'h7) miss_reg <= miss_reg + 3'h1;
        gap_reg <= drive_cycle_o ? 24'h1 : gap_reg + 24'h1;
        prev_reg <= open_loop_o && (prev_reg || drive_cycle_o);
        if (rst_i) begin
            cfg_reg <= 2'h2;
            ctl_reg <= 8'h00;
            per_reg <= 10'h0C6;
            prev_reg <= 1'b0;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_run_len;
        $rose(cal_measure_o) && code_reg != 2'h3 |-> run_reg + 28'h1 >= cal_len && run_reg <= cal_len + 28'h1;
    endproperty
    a_run_len: assert property (p_run_len) else $error("fixed run length wrong");
    property p_wait_hold;
        code_reg == 2'h3 && cal_busy_o && !cal_measure_o && !trig |=> !cal_measure_o;
    endproperty
    a_wait_hold: assert property (p_wait_hold) else $error("measure without trigger");
    property p_trig_meas;
        code_reg == 2'h3 && cal_busy_o && !cal_measure_o && trig |=> cal_measure_o;
    endproperty
    a_trig_meas: assert property (p_trig_meas) else $error("trigger did not end run");
    // The repetition count matches the measurement length the bench sets.
    property p_meas_len;
        $rose(cal_measure_o) |-> cal_measure_o [*3] ##1 (cal_done_o && !cal_busy_o);
    endproperty
    a_meas_len: assert property (p_meas_len) else $error("measure phase length wrong");
    property p_fb_count;
        $rose(fallback_active_o) |-> ctl_reg[7] && miss_reg == 3'h3 + {1'b0, ctl_reg[6:5]};
    endproperty
    a_fb_count: assert property (p_fb_count) else $error("fallback at wrong count");
    property p_fb_set;
        ctl_reg[7] && closed_loop_active_i && win && !zero_crossing_seen_i
            && miss_reg == 3'h2 + {1'b0, ctl_reg[6:5]} |=> fallback_active_o;
    endproperty
    a_fb_set: assert property (p_fb_set) else $error("fallback missing");
    property p_sine;
        drive_sine_o == (open_loop_req_i && ctl_reg[0] && !fallback_active_o)
            && open_loop_o == (open_loop_req_i || fallback_active_o);
    endproperty
    a_sine: assert property (p_sine) else $error("drive shape wrong");
    property p_period;
        drive_cycle_o && prev_reg |-> gap_reg == per_len;
    endproperty
    a_period: assert property (p_period) else $error("drive period wrong");
    c_trig_cal: cover property (cal_done_o && code_reg == 2'h3);
    c_fallback: cover property ($rose(fallback_active_o));
    c_period: cover property (drive_cycle_o && prev_reg);
endmodule // acl_cal_open_loop_sva
bind acl_cal_open_loop acl_cal_open_loop_sva #(.CAL0_CYCLES(CAL0_CYCLES),
    .CAL1_CYCLES(CAL1_CYCLES), .CAL2_CYCLES(CAL2_CYCLES), .OL_UNIT_CYCLES(OL_UNIT_CYCLES)) u_sva (.*);
`default_nettype wire

// [bench/acl_host_model.sv]
// Host-side model issuing register accesses and pacing trigger-mode calibration.
`timescale 1ns/100ps
`default_nettype none
module acl_host_model #(
    parameter int MIN_RUN = 100
) (
    input wire logic clk_i,
    input wire logic [7:0] rdata_i,
    output logic [7:0] addr_o,
    output logic [7:0] wdata_o,
    output logic wr_o,
    output logic rd_o
);
    initial begin
        addr_o = 8'h00;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    // Released address and data lines are inverted so a stale value is never mistaken for a live one.
    task acc(input logic w, input logic [7:0] a, dt);
        @(posedge clk_i);
        #1;
        addr_o = a;
        wdata_o = dt;
        wr_o = w;
        rd_o = !w;
        @(posedge clk_i);
        #1;
        wr_o = 1'b0;
        rd_o = 1'b0;
        addr_o = ~addr_o;
        wdata_o = ~wdata_o;
    endtask
    task wr(input logic [7:0] a, dt);
        acc(1'b1, a, dt);
    endtask
    task rd(input logic [7:0] a, output logic [7:0] d);
        acc(1'b0, a, 8'h00);
        d = rdata_i;
    endtask
    // Trigger-mode runs are held long enough for the actuator to settle.
    task hold_run;
        repeat (MIN_RUN) @(posedge clk_i);
        #1;
    endtask
endmodule // acl_host_model
`default_nettype wire

// [bench/acl_cal_open_loop_tb_top.sv]
// Self-checking bench for the calibration and open-loop configuration block.
`timescale 1ns/100ps
`default_nettype none
module acl_cal_open_loop_tb_top;
    logic clk_i = 0, rst_i = 1, st = 0, tx = 0, te = 0, ts = 0, cl = 0, rq = 0, zw = 0, zs = 0;
    logic [7:0] addr, wdata, rdata, d;
    logic wr, rd, busy, meas, done, ol, fb, sine, cyc, pol;
    int bad_count = 0, samples_checked = 0, n, hc;
    logic [7:0] ra [5] = '{8'h2A, 8'h2C, 8'h2E, 8'h2F, 8'h2B};
    logic [7:0] re [5] = '{8'h02, 8'h00, 8'h00, 8'hC6, 8'h00};
    acl_cal_open_loop #(.CAL0_CYCLES(20), .CAL1_CYCLES(40), .CAL2_CYCLES(80), .MEAS_CYCLES(3),
        .OL_UNIT_CYCLES(4)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(addr),
        .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .cal_start_i(st), .ext_trig_i(tx), .enable_trig_i(te), .sw_trig_i(ts),
        .cal_busy_o(busy), .cal_measure_o(meas), .cal_done_o(done), .closed_loop_active_i(cl),
        .open_loop_req_i(rq), .zero_crossing_window_i(zw), .zero_crossing_seen_i(zs),
        .open_loop_o(ol), .fallback_active_o(fb), .drive_sine_o(sine),
        .drive_polarity_o(pol), .drive_cycle_o(cyc));
    acl_host_model #(.MIN_RUN(100)) u_host (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr),
        .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
    initial forever #2.5 clk_i = ~clk_i;
    task stop_test;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, g);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Bounded wait for the done pulse (sel 0) or the drive period pulse (sel 1).
    task wt(input bit sel, input int lim);
        n = 0;
        hc = 0;
        do begin
            @(posedge clk_i);
            #1;
            n++;
            hc += pol;
        end while ((sel ? cyc : done) !== 1'b1 && n < lim);
        if ((sel ? cyc : done) !== 1'b1) begin
            bad_count++;
            stop_test;
        end
    endtask
    task automatic pulse(ref logic s);
        @(posedge clk_i);
        #1;
        s = 1;
        @(posedge clk_i);
        #1;
        s = 0;
    endtask
    task zc(input logic s);
        zs = s;
        pulse(zw);
    endtask
    task t_regs;
        for (int i = 0; i < 5; i++) begin
            u_host.rd(ra[i], d);
            chk("reset value", re[i], d);
            u_host.wr(ra[i], 8'hFD);
            u_host.rd(ra[i], d);
            chk("read back", i < 4 ? 8'hFD : 8'h00, d);
        end
        // A reset in the middle of a run must abandon it and restore every register.
        pulse(st);
        rst_i = 1;
        repeat (2) @(posedge clk_i);
        #1;
        rst_i = 0;
        chk("reset busy", 3'h0, {busy, meas, done});
        for (int i = 0; i < 4; i++) begin
            u_host.rd(ra[i], d);
            chk("reset again", re[i], d);
        end
    endtask
    task t_cal_fixed;
        for (int c = 0; c < 3; c++) begin
            u_host.wr(8'h2A, 8'(c));
            pulse(st);
            // A trigger and a second start during a fixed run must both be ignored.
            pulse(ts);
            pulse(st);
            wt(0, 200);
            chk("cal length", 1, n >= (20 << c) - 2 && n <= (20 << c) + 1);
        end
    endtask
    task t_cal_trig;
        u_host.wr(8'h2A, 8'h03);
        for (int t = 0; t < 3; t++) begin
            pulse(st);
            u_host.hold_run;
            chk("waiting", 3'h4, {busy, meas, done});
            if (t == 0) pulse(tx);
            else if (t == 1) pulse(te);
            else pulse(ts);
            wt(0, 20);
            chk("measure time", 1, n >= 2 && n <= 4);
        end
    endtask
    task t_fallback;
        cl = 1;
        rq = 1;
        for (int k = 0; k < 4; k++) begin
            u_host.wr(8'h2C, {1'b1, k[1:0], 5'h01});
            zc(0);
            zc(1);
            repeat (k + 2) zc(0);
            chk("fallback early", 0, fb);
            zc(0);
            chk("fallback", 3'h6, {fb, ol, sine});
            cl = 0;
            @(posedge clk_i);
            #1;
            chk("released", 3'h3, {fb, ol, sine});
            cl = 1;
        end
        u_host.wr(8'h2C, 8'h00);
        repeat (6) zc(0);
        chk("fallback off", 3'h2, {fb, ol, sine});
        cl = 0;
        rq = 0;
    endtask
    task t_period(input logic [7:0] hi, lo, input int exp, hi_exp);
        u_host.wr(8'h2E, hi);
        u_host.wr(8'h2F, lo);
        rq = 1;
        wt(1, 5000);
        wt(1, 5000);
        chk("period", exp, n);
        chk("polarity high", hi_exp, hc);
        rq = 0;
    endtask
    initial begin
        repeat (2) @(posedge clk_i);
        #1;
        rst_i = 0;
        t_regs;
        t_cal_fixed;
        t_cal_trig;
        t_fallback;
        t_period(8'h00, 8'h06, 24, 12);
        t_period(8'h02, 8'h01, 2052, 1028);
        stop_test;
    end
endmodule // acl_cal_open_loop_tb_top
`default_nettype wire
